// File: inc/slc_pkg.sv
// Constants of the link configuration register bank.
// Assumes a 40 MHz core clock and byte-wide register access.
package slc_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_TIMING = 8'h13;
	localparam logic [7:0] OFS_LEVEL = 8'h14;
	localparam logic [7:0] OFS_TRIG = 8'h15;
	localparam logic [7:0] OFS_RSVD = 8'h16;
	// ==========================================
	// Field positions
	localparam int B_LACK = 7;
	localparam int B_SHS = 5;
	localparam int B_MRS = 2;
	localparam int B_STO = 0;
	localparam int B_LVL = 4;
	localparam int B_RWD = 0;
	localparam int B_DTD = 7;
	localparam int B_CPT = 5;
	localparam int B_RPE = 4;
	localparam int B_RNE = 3;
	// ==========================================
	// Reset values
	localparam logic RST_LACK = 1'h1;
	localparam logic [1:0] RST_SHS = 2'h1;
	localparam logic [2:0] RST_MRS = 3'h5;
	localparam logic [1:0] RST_STO = 2'h2;
	localparam logic [3:0] RST_LVL = 4'ha;
	localparam logic RST_RWD = 1'h0;
	localparam logic RST_DTD = 1'h0;
	localparam logic [1:0] RST_CPT = 2'h2;
	localparam logic RST_RPE = 1'h1;
	localparam logic RST_RNE = 1'h0;
	localparam logic [7:0] RST_RSVD = 8'h00;
	// Fixed patterns of the reserved slices
	localparam logic [2:0] LVL_RSV = 3'h0;
	localparam logic [2:0] TRIG_RSV = 3'h2;
	// ==========================================
	// Codes
	localparam logic [3:0] LVL_MIN = 4'h1;
	localparam logic [3:0] LVL_MAX = 4'ha;
	localparam logic [1:0] STO_OFF = 2'h3;
	localparam logic [1:0] CPT_NEVER = 2'h0;
	localparam logic [1:0] CPT_ALWAYS = 2'h1;
	localparam logic [1:0] CPT_DE_LOW = 2'h2;
	localparam logic [1:0] CPT_HS_LOW = 2'h3;
	// ==========================================
	// Timing; least times round up
	localparam int CLK_MHZ = 40;
	localparam int SU0_NS = 352;
	localparam int HD0_NS = 117;
	localparam int SU1_NS = 469;
	localparam int HD1_NS = 234;
	localparam int SU2_NS = 938;
	localparam int HD2_NS = 352;
	localparam int SU3_NS = 1046;
	localparam int HD3_NS = 469;
	localparam int TMO0_US = 64;
	localparam int TMO1_US = 256;
	localparam int TMO2_US = 1024;
	localparam int TMO0_CYC = TMO0_US * CLK_MHZ;
	function automatic logic [5:0] ns2cyc(input int ns);
		ns2cyc = 6'((ns * CLK_MHZ + 999) / 1000);
	endfunction
endpackage

// File: design/slc_config_regs.sv
// Link configuration register bank: bridge timing, coax level,
// packet trigger and reverse-channel enables.
// Assumes the control channel delivers byte accesses in core_clk.
//
// How it works
// - Local ack bit set: slave acks locally when forward channel down.
// - Two-bit field picks I2C setup/hold pair; resets to 01.
// - Three-bit field picks master bit rate, 8.47 to 837 kbps.
// - Timeout field: 64, 256, 1024 us, or none; resets to 10.
// - Level code 1..10 gives 50..500 mV; other codes must not be written.
// - Level register bit 0 at 1 disables wake receiver and remote wake.
// - Trigger-disable bit 0 lets data enable start packets in fast mode.
// - Control packets in fast mode: never, always, data enable low, hsync low.
// - Positive coax wire reverse channel enabled by its bit, resets 1.
// - Negative coax wire reverse channel enabled by its bit, resets 0.
`timescale 1ns/1ps
module slc_config_regs #(
	parameter int TMO1_CYC = slc_pkg::TMO1_US * slc_pkg::CLK_MHZ,
	parameter int TMO2_CYC = slc_pkg::TMO2_US * slc_pkg::CLK_MHZ
) (
	input wire logic core_clk, // 40 MHz clock
	input wire logic rst_n, // Async reset
	input wire logic [7:0] reg_addr, // Register address
	input wire logic reg_wr, // Write strobe
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_rd, // Read strobe
	output logic [7:0] reg_rdata, // Read data, held
	input wire logic ack_request, // Slave must answer
	input wire logic fwd_unavailable, // Forward channel down
	input wire logic high_bw_mode, // High-bandwidth mode
	input wire logic data_enable_input, // Video DE
	input wire logic horizontal_sync, // Video HS
	input wire logic coax_mode, // Coax cable in use
	output logic slave_local_ack, // Local ack
	output logic [1:0] slave_setup_hold_select, // Field
	output logic [5:0] setup_cycles, // Setup time
	output logic [5:0] hold_cycles, // Hold time
	output logic [2:0] master_rate_select, // Field
	output logic [1:0] slave_remote_timeout, // Field
	output logic timeout_enable, // Timeout active
	output logic [15:0] timeout_cycles, // Timeout length
	output logic [3:0] coax_level_code, // Level field
	output logic remote_wake_disable, // Field
	output logic wake_rx_enable, // Wake receiver on
	output logic de_trigger_disable, // Field
	output logic [1:0] control_packet_trigger, // Field
	output logic de_packet_trigger, // DE starts packet
	output logic control_signal_packets_packet_send, // Control packet
	output logic reverse_positive_enable, // Field
	output logic reverse_negative_enable, // Field
	output logic rev_pos_rx, // Receive on + wire
	output logic rev_neg_rx // Receive on - wire
);
	// ==========================================
	// State
	typedef struct packed {
		logic lack;
		logic [1:0] shs;
		logic [2:0] mrs;
		logic [1:0] sto;
		logic [3:0] lvl;
		logic rwd;
		logic dtd;
		logic [1:0] cpt;
		logic rpe;
		logic rne;
		logic [7:0] rsvd;
		logic [7:0] rdata;
		logic ack;
		logic [5:0] su;
		logic [5:0] hd;
		logic [15:0] tmo;
		logic dep;
		logic cps;
		logic rpx;
		logic rnx;
	} slc_state_t;

	slc_state_t s_q, s_d;
	logic [7:0] rd_byte;

	// ==========================================
	// Read mux; reserved slices read as their fixed patterns
	always_comb begin
		case (reg_addr)
		slc_pkg::OFS_TIMING: begin
			rd_byte = {s_q.lack, s_q.shs, s_q.mrs, s_q.sto};
		end
		slc_pkg::OFS_LEVEL: begin
			rd_byte = {s_q.lvl, slc_pkg::LVL_RSV, s_q.rwd};
		end
		slc_pkg::OFS_TRIG: begin
			rd_byte = {s_q.dtd, s_q.cpt, s_q.rpe, s_q.rne,
				slc_pkg::TRIG_RSV};
		end
		slc_pkg::OFS_RSVD: begin
			rd_byte = s_q.rsvd;
		end
		default: begin
			rd_byte = 8'h00;
		end
		endcase
	end

	// ==========================================
	// Next state
	always_comb begin
		logic [3:0] wl;
		wl = reg_wdata[slc_pkg::B_LVL +: 4];
		s_d = s_q;
		if (reg_wr) begin
			case (reg_addr)
			slc_pkg::OFS_TIMING: begin
				s_d.lack = reg_wdata[slc_pkg::B_LACK];
				s_d.shs = reg_wdata[slc_pkg::B_SHS +: 2];
				s_d.mrs = reg_wdata[slc_pkg::B_MRS +: 3];
				s_d.sto = reg_wdata[slc_pkg::B_STO +: 2];
			end
			slc_pkg::OFS_LEVEL: begin
				// Forbidden codes could overdrive the line; keep old
				if (wl >= slc_pkg::LVL_MIN && wl <= slc_pkg::LVL_MAX) begin
					s_d.lvl = wl;
				end
				s_d.rwd = reg_wdata[slc_pkg::B_RWD];
			end
			slc_pkg::OFS_TRIG: begin
				s_d.dtd = reg_wdata[slc_pkg::B_DTD];
				s_d.cpt = reg_wdata[slc_pkg::B_CPT +: 2];
				s_d.rpe = reg_wdata[slc_pkg::B_RPE];
				s_d.rne = reg_wdata[slc_pkg::B_RNE];
			end
			slc_pkg::OFS_RSVD: begin
				s_d.rsvd = reg_wdata;
			end
			default: begin
			end
			endcase
		end
		if (reg_rd) begin
			s_d.rdata = rd_byte;
		end
		s_d.ack = ack_request & fwd_unavailable & s_q.lack;
		case (s_q.shs)
		2'h0: begin
			s_d.su = slc_pkg::ns2cyc(slc_pkg::SU0_NS);
			s_d.hd = slc_pkg::ns2cyc(slc_pkg::HD0_NS);
		end
		2'h1: begin
			s_d.su = slc_pkg::ns2cyc(slc_pkg::SU1_NS);
			s_d.hd = slc_pkg::ns2cyc(slc_pkg::HD1_NS);
		end
		2'h2: begin
			s_d.su = slc_pkg::ns2cyc(slc_pkg::SU2_NS);
			s_d.hd = slc_pkg::ns2cyc(slc_pkg::HD2_NS);
		end
		default: begin
			s_d.su = slc_pkg::ns2cyc(slc_pkg::SU3_NS);
			s_d.hd = slc_pkg::ns2cyc(slc_pkg::HD3_NS);
		end
		endcase
		case (s_q.sto)
		2'h0: begin
			s_d.tmo = 16'(slc_pkg::TMO0_CYC);
		end
		2'h1: begin
			s_d.tmo = 16'(TMO1_CYC);
		end
		2'h2: begin
			s_d.tmo = 16'(TMO2_CYC);
		end
		default: begin
			s_d.tmo = 16'h0000;
		end
		endcase
		s_d.dep = high_bw_mode & ~s_q.dtd & data_enable_input;
		case (s_q.cpt)
		slc_pkg::CPT_NEVER: begin
			s_d.cps = 1'b0;
		end
		slc_pkg::CPT_ALWAYS: begin
			s_d.cps = high_bw_mode;
		end
		slc_pkg::CPT_DE_LOW: begin
			s_d.cps = high_bw_mode & ~data_enable_input;
		end
		default: begin
			s_d.cps = high_bw_mode & ~horizontal_sync;
		end
		endcase
		s_d.rpx = coax_mode & s_q.rpe;
		s_d.rnx = coax_mode & s_q.rne;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.lack <= slc_pkg::RST_LACK;
			s_q.shs <= slc_pkg::RST_SHS;
			s_q.mrs <= slc_pkg::RST_MRS;
			s_q.sto <= slc_pkg::RST_STO;
			s_q.lvl <= slc_pkg::RST_LVL;
			s_q.rwd <= slc_pkg::RST_RWD;
			s_q.dtd <= slc_pkg::RST_DTD;
			s_q.cpt <= slc_pkg::RST_CPT;
			s_q.rpe <= slc_pkg::RST_RPE;
			s_q.rne <= slc_pkg::RST_RNE;
			s_q.rsvd <= slc_pkg::RST_RSVD;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs
	assign reg_rdata = s_q.rdata;
	assign slave_local_ack = s_q.ack;
	assign slave_setup_hold_select = s_q.shs;
	assign setup_cycles = s_q.su;
	assign hold_cycles = s_q.hd;
	assign master_rate_select = s_q.mrs;
	assign slave_remote_timeout = s_q.sto;
	assign timeout_enable = (s_q.sto != slc_pkg::STO_OFF);
	assign timeout_cycles = s_q.tmo;
	assign coax_level_code = s_q.lvl;
	assign remote_wake_disable = s_q.rwd;
	assign wake_rx_enable = ~s_q.rwd;
	assign de_trigger_disable = s_q.dtd;
	assign control_packet_trigger = s_q.cpt;
	assign de_packet_trigger = s_q.dep;
	assign control_signal_packets_packet_send = s_q.cps;
	assign reverse_positive_enable = s_q.rpe;
	assign reverse_negative_enable = s_q.rne;
	assign rev_pos_rx = s_q.rpx;
	assign rev_neg_rx = s_q.rnx;

	// ==========================================
	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_local_ack;
		ack_request && fwd_unavailable && slave_local_ack == 1'b0
			&& s_q.lack && !reg_wr |=> slave_local_ack;
	endproperty
	a_local_ack: assert property (p_local_ack)
		else $error("local ack missing");

	property p_no_ack;
		!s_q.lack |=> !slave_local_ack;
	endproperty
	a_no_ack: assert property (p_no_ack)
		else $error("ack while disabled");

	property p_setup;
		slave_setup_hold_select == 2'h2 && !reg_wr
			|=> setup_cycles == slc_pkg::ns2cyc(slc_pkg::SU2_NS)
			&& hold_cycles == slc_pkg::ns2cyc(slc_pkg::HD2_NS);
	endproperty
	a_setup: assert property (p_setup)
		else $error("setup/hold mismatch");

	property p_tmo;
		reg_wr && reg_addr == slc_pkg::OFS_TIMING
			&& reg_wdata[1:0] == slc_pkg::STO_OFF
			|=> !timeout_enable ##1 timeout_cycles == 16'h0000;
	endproperty
	a_tmo: assert property (p_tmo)
		else $error("timeout not disabled");

	property p_level;
		reg_wr && reg_addr == slc_pkg::OFS_LEVEL
			&& reg_wdata[7:4] > slc_pkg::LVL_MAX
			|=> $stable(coax_level_code);
	endproperty
	a_level: assert property (p_level)
		else $error("forbidden level taken");

	property p_wake;
		reg_wr && reg_addr == slc_pkg::OFS_LEVEL && reg_wdata[0]
			|=> !wake_rx_enable;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake receiver still on");

	property p_de_trig;
		high_bw_mode && data_enable_input && !s_q.dtd
			|=> de_packet_trigger;
	endproperty
	a_de_trig: assert property (p_de_trig)
		else $error("DE trigger missing");

	property p_control_signal_packets;
		control_packet_trigger == slc_pkg::CPT_HS_LOW && high_bw_mode
			&& horizontal_sync |=> !control_signal_packets_packet_send;
	endproperty
	a_control_signal_packets: assert property (p_control_signal_packets)
		else $error("control packet outside hsync low");

	property p_revp;
		!coax_mode |=> !rev_pos_rx && !rev_neg_rx;
	endproperty
	a_revp: assert property (p_revp)
		else $error("reverse rx without coax");

	property p_revn;
		coax_mode && !reverse_negative_enable |=> !rev_neg_rx;
	endproperty
	a_revn: assert property (p_revn)
		else $error("negative wire rx while disabled");
endmodule

// File: verification/slc_host_model.sv
// Host model: the microcontroller that programs the link configuration
// registers one byte at a time. Assumes strobes sampled on core_clk rise.
`timescale 1ns/1ps
module slc_host_model (
	input wire logic core_clk, // Bank clock
	input wire logic [7:0] reg_rdata, // Read data
	output logic [7:0] reg_addr, // Byte address
	output logic reg_wr, // Write strobe
	output logic [7:0] reg_wdata, // Write data
	output logic reg_rd // Read strobe
);
	// Set only by a scenario that wants a forbidden level code refused
	logic allow_bad_level = 1'b0;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// ==========================================
	// Accesses
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == slc_pkg::OFS_LEVEL)
			v[3:1] = slc_pkg::LVL_RSV;
		if (a == slc_pkg::OFS_TRIG)
			v[2:0] = slc_pkg::TRIG_RSV;
		if (a == slc_pkg::OFS_RSVD)
			return;
		if (a == slc_pkg::OFS_LEVEL && !allow_bad_level &&
			(v[7:4] < slc_pkg::LVL_MIN || v[7:4] > slc_pkg::LVL_MAX))
			return;
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		// Idle lines carry junk so nothing leans on stale values
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// File: verification/slc_config_regs_tb.sv
// Self-checking bench for the link configuration register bank.
// Assumes the host model drives the register port; video inputs here.
`timescale 1ns/1ps
module slc_config_regs_tb;
	logic core_clk, rst_n, reg_wr, reg_rd, ack_request, fwd_unavailable;
	logic high_bw_mode, data_enable_input, horizontal_sync, coax_mode;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, v;
	logic [5:0] setup_cycles, hold_cycles;
	logic [15:0] timeout_cycles;
	logic [3:0] coax_level_code, lvl;
	logic [2:0] master_rate_select;
	logic [1:0] slave_setup_hold_select, slave_remote_timeout;
	logic [1:0] control_packet_trigger, cpt;
	logic slave_local_ack, timeout_enable, remote_wake_disable;
	logic wake_rx_enable, de_trigger_disable, de_packet_trigger;
	logic control_signal_packets_packet_send, reverse_positive_enable, reverse_negative_enable;
	logic rev_pos_rx, rev_neg_rx, ce;
	int n_mismatch, n_checks;
	logic [5:0] su_exp [4] = '{6'h0f, 6'h13, 6'h26, 6'h2a};
	logic [5:0] hd_exp [4] = '{6'h05, 6'h0a, 6'h0f, 6'h13};
	logic [15:0] to_exp [4] = '{16'h0a00, 16'h0064, 16'h00c8, 16'h0000};

	// Short timeouts keep the run small
	slc_config_regs #(.TMO1_CYC(100), .TMO2_CYC(200)) slc_config_regs_inst (
		.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata, .ack_request, .fwd_unavailable, .high_bw_mode,
		.data_enable_input, .horizontal_sync, .coax_mode, .slave_local_ack,
		.slave_setup_hold_select, .setup_cycles, .hold_cycles,
		.master_rate_select, .slave_remote_timeout, .timeout_enable,
		.timeout_cycles, .coax_level_code, .remote_wake_disable,
		.wake_rx_enable, .de_trigger_disable, .control_packet_trigger,
		.de_packet_trigger, .control_signal_packets_packet_send, .reverse_positive_enable,
		.reverse_negative_enable, .rev_pos_rx, .rev_neg_rx
	);

	slc_host_model slc_host_model_inst (
		.core_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd
	);

	// ==========================================
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		slc_host_model_inst.read_reg(a, rd_val);
		check(16'(rd_val), 16'(e));
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Run is far shorter; reaching this means something hung
	initial begin
		#2000000;
		n_mismatch++;
		finish_test();
	end

	// ==========================================
	// Scenarios
	initial begin
		rst_n = 1'b0;
		ack_request = 1'b0;
		fwd_unavailable = 1'b0;
		high_bw_mode = 1'b0;
		data_enable_input = 1'b0;
		horizontal_sync = 1'b0;
		coax_mode = 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		check(16'(setup_cycles), 16'h0013);
		check(timeout_cycles, 16'h00c8);
		rd(slc_pkg::OFS_TIMING, 8'hb6);
		rd(slc_pkg::OFS_LEVEL, 8'ha0);
		rd(slc_pkg::OFS_TRIG, 8'h52);
		rd(slc_pkg::OFS_RSVD, 8'h00);
		rd(8'h20, 8'h00);
		@(posedge core_clk);
		ack_request <= 1'b1;
		fwd_unavailable <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = {i[0], i[1:0], i[2:0], i[1:0]};
			slc_host_model_inst.write_reg(slc_pkg::OFS_TIMING, v);
			rd(slc_pkg::OFS_TIMING, v);
			check(16'(master_rate_select), 16'(i[2:0]));
			check(16'(slave_setup_hold_select), 16'(i[1:0]));
			check(16'(slave_remote_timeout), 16'(i[1:0]));
			check(16'(slave_local_ack), 16'(i[0]));
			check(16'(setup_cycles), 16'(su_exp[i[1:0]]));
			check(16'(hold_cycles), 16'(hd_exp[i[1:0]]));
			check(timeout_cycles, to_exp[i[1:0]]);
			check(16'(timeout_enable), 16'(i[1:0] != 2'h3));
		end
		@(posedge core_clk);
		fwd_unavailable <= 1'b0;
		@(posedge core_clk);
		#1;
		check(16'(slave_local_ack), 16'h0000);
		slc_host_model_inst.allow_bad_level = 1'b1;
		lvl = slc_pkg::LVL_MAX;
		for (int c = 0; c < 16; c++) begin
			slc_host_model_inst.write_reg(slc_pkg::OFS_LEVEL, {c[3:0], 4'(c[0])});
			if (c >= 1 && c <= 10)
				lvl = c[3:0];
			rd(slc_pkg::OFS_LEVEL, {lvl, 3'h0, c[0]});
			check(16'(coax_level_code), 16'(lvl));
			check(16'(wake_rx_enable), 16'(!c[0]));
			check(16'(remote_wake_disable), 16'(c[0]));
		end
		for (int i = 0; i < 16; i++) begin
			v = {i[0], i[2:1], i[3], i[0] ^ i[3], 3'h2};
			cpt = v[6:5];
			slc_host_model_inst.write_reg(slc_pkg::OFS_TRIG, v);
			rd(slc_pkg::OFS_TRIG, v);
			check(16'(de_trigger_disable), 16'(v[7]));
			check(16'(control_packet_trigger), 16'(cpt));
			check(16'(reverse_positive_enable), 16'(v[4]));
			check(16'(reverse_negative_enable), 16'(v[3]));
			for (int j = 0; j < 8; j++) begin
				@(posedge core_clk);
				high_bw_mode <= j[2];
				data_enable_input <= j[0];
				horizontal_sync <= j[1];
				coax_mode <= j[1] | j[2];
				@(posedge core_clk);
				#1;
				ce = high_bw_mode & ((cpt == slc_pkg::CPT_ALWAYS) |
					(cpt == slc_pkg::CPT_DE_LOW & !data_enable_input) |
					(cpt == slc_pkg::CPT_HS_LOW & !horizontal_sync));
				check(16'(de_packet_trigger),
					16'(high_bw_mode & !v[7] & data_enable_input));
				check(16'(control_signal_packets_packet_send), 16'(ce));
				check(16'(rev_pos_rx), 16'(coax_mode & v[4]));
				check(16'(rev_neg_rx), 16'(coax_mode & v[3]));
			end
		end
		// Second reset must restore every field after heavy use
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(slc_pkg::OFS_TIMING, 8'hb6);
		rd(slc_pkg::OFS_LEVEL, 8'ha0);
		rd(slc_pkg::OFS_TRIG, 8'h52);
		check(16'(rev_pos_rx), 16'(coax_mode));
		check(16'(rev_neg_rx), 16'h0000);
		finish_test();
	end
endmodule
